// ==== rtl/plldh_pkg.sv ====
// Purpose: Shared constants and types for the lock detect and holdover block.
// Assumes: Core clock of 25 MHz; one phase comparison result per qualify strobe.
// Notes: Register port is address, write data, write and read strobes.
// Notes on behaviour
// [R1] Lock rises after the programmed count of in-window comparisons in a row.
// [R2] Lock falls at once on any comparison outside the window.
// [R3] With the trigger-off bit at 0, falling lock enters holdover.
// [R4] In holdover, valid reference and exit criteria leave holdover and restart locking.
// [R5] Holdover is enabled only when the holdover mode field equals 2.
// [R6] Tracking bit at 0 stops tuning value tracking for holdover.
// [R7] Manual select at 1 drives holdover tuning from the manual value.
// [R8] Manual code 512 gives about half supply on the tuning output.
// [R9] Software must program a count large enough to avoid holdover chatter.
// [R10] Lock time follows count times comparison period; larger count is longer.
// [R11] Manual tune value is a 10-bit field; 512 is mid range.
package plldh_pkg;
   localparam int ADDR_W = 4;
   localparam int CNT_W = 14;
   localparam int WIN_W = 4;
   localparam int DAC_W = 10;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_COUNT = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_DAC = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h5;
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_TRACK_BIT = 2;
   localparam int CTRL_MANSEL_BIT = 3;
   localparam int CTRL_TRIGOFF_BIT = 4;
   localparam int CTRL_WIN_LSB = 8;
   localparam logic [1:0] HOLDOVER_MODE_ON = 2'h2;
   localparam logic [CNT_W-1:0] COUNT_RST = 14'h2710;
   localparam logic [DAC_W-1:0] DAC_MID = 10'h200;
   localparam logic [WIN_W-1:0] WIN_RST = 4'h4;
   localparam int IRQ_LOCK = 0;
   localparam int IRQ_LOSS = 1;
   localparam int IRQ_HO_IN = 2;
   localparam int IRQ_HO_OUT = 3;
   localparam int IRQ_W = 4;
   localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
   typedef struct packed {
      logic [1:0] mode;
      logic track_en;
      logic manual_tune_select;
      logic lockloss_holdover_trigger_off;
      logic [WIN_W-1:0] phase_window_size;
      logic [CNT_W-1:0] lock_qualify_count;
      logic [DAC_W-1:0] manual_tune_value;
   } plldh_cfg_t;
endpackage

// ==== rtl/plldh_sync.sv ====
// Purpose: Three-flop synchroniser; output changes when stages two and three agree.
// Assumes: Input is asynchronous to i_core_clk.
// Notes: Stage one feeds only stage two.
`timescale 1ns/1ps
module plldh_sync (
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   input wire logic i_ce,
   input wire logic i_async,
   output logic o_sync
);
   logic [2:0] stage_reg;
   logic [2:0] stage_next;
   logic out_reg;
   logic out_next;

   // Shift and accept a change only once two late stages match.
   always_comb begin
      stage_next = {stage_reg[1:0], i_async};
      out_next = (stage_reg[1] == stage_reg[2]) ? stage_reg[2] : out_reg;
   end

   // Registers only.
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         stage_reg <= 3'h0;
         out_reg <= 1'b0;
      end else if (i_ce) begin
         stage_reg <= stage_next;
         out_reg <= out_next;
      end
   end

   assign o_sync = out_reg;
endmodule // plldh_sync

// ==== rtl/plldh_top.sv ====
// Purpose: Digital lock detect and holdover control for the first loop.
// Assumes: i_cmp_strobe marks one phase comparison per detector cycle, with
//          i_phase_err its magnitude in window units; same clock domain.
// Notes: i_ref_valid arrives from a pin and is synchronised here.
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module plldh_top (
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   input wire logic i_ce,
   input wire logic [plldh_pkg::ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_cmp_strobe,
   input wire logic [plldh_pkg::WIN_W-1:0] i_phase_err,
   input wire logic [plldh_pkg::DAC_W-1:0] i_track_code,
   input wire logic i_ref_valid,
   output logic [31:0] o_rdata,
   output logic o_lock_indication,
   output logic o_holdover,
   output logic o_relock_start,
   output logic [plldh_pkg::DAC_W-1:0] o_tune_code,
   output logic o_tune_hold,
   output logic o_irq
);
   plldh_pkg::plldh_cfg_t cfg_reg, cfg_next;
   logic [plldh_pkg::IRQ_W-1:0] ist_reg, ist_next, imask_reg, imask_next;
   logic [31:0] rdata_reg, rdata_next;
   logic irq_reg, irq_next;
   logic [plldh_pkg::CNT_W-1:0] qcnt_reg, qcnt_next;
   logic lock_reg, lock_next;
   logic ho_reg, ho_next;
   logic relock_reg, relock_next;
   logic [plldh_pkg::DAC_W-1:0] held_reg, held_next, tune_reg, tune_next;
   logic ref_ok;
   logic in_win, ho_enabled, ho_enter, ho_exit;
   logic [plldh_pkg::IRQ_W-1:0] ev;

   plldh_sync u_ref_sync (
      .i_core_clk(i_core_clk),
      .i_arst_n(i_arst_n),
      .i_ce(i_ce),
      .i_async(i_ref_valid),
      .o_sync(ref_ok)
   );

   // Decisions made from current state; shared by the lock and holdover groups below.
   always_comb begin
      in_win = (i_phase_err <= cfg_reg.phase_window_size);
      ho_enabled = (cfg_reg.mode == plldh_pkg::HOLDOVER_MODE_ON); // R5
      // Exit criteria: reference valid again and still in holdover.
      ho_exit = ho_reg && ref_ok; // R4
   end

   // Lock qualification counter; the count sets lock time in comparisons.
   always_comb begin
      qcnt_next = qcnt_reg;
      lock_next = lock_reg;
      if (ho_exit) begin
         qcnt_next = '0; // R4
         lock_next = 1'b0;
      end else if (i_cmp_strobe) begin
         if (!in_win) begin
            qcnt_next = '0;
            lock_next = 1'b0; // R2
         end else if (qcnt_reg + 14'h0001 >= cfg_reg.lock_qualify_count) begin
            lock_next = 1'b1; // R1 R10
         end else begin
            qcnt_next = qcnt_reg + 14'h0001; // R10
         end
      end
   end

   // Holdover state and the tuning value driven during it.
   always_comb begin
      // A falling lock starts holdover when the mode enables it, unless the trigger is turned off.
      // Kept here, not with the shared decisions, so that no process
      // both feeds and reads the lock group.
      ho_enter = ho_enabled && !ho_reg && lock_reg && !lock_next &&
         !cfg_reg.lockloss_holdover_trigger_off; // R3
      ho_next = ho_reg;
      relock_next = 1'b0;
      held_next = held_reg;
      if (ho_enter) begin
         ho_next = 1'b1;
      end else if (ho_exit) begin
         ho_next = 1'b0;
         relock_next = 1'b1; // R4
      end
      if (!ho_enabled) begin
         ho_next = 1'b0;
      end
      // Tracking follows the loop only while locked, so a failing loop
      // does not drag the held value with it.
      if (cfg_reg.track_en && lock_reg && !ho_reg) begin
         held_next = i_track_code; // R6
      end
      if (ho_reg && cfg_reg.manual_tune_select) begin
         tune_next = cfg_reg.manual_tune_value; // R7 R8 R11
      end else if (ho_reg && cfg_reg.track_en) begin
         tune_next = held_reg;
      end else if (ho_reg) begin
         tune_next = plldh_pkg::DAC_MID; // R8
      end else begin
         tune_next = i_track_code;
      end
   end

   // Register port, sticky status with write-one-to-clear, and interrupt.
   always_comb begin
      cfg_next = cfg_reg;
      imask_next = imask_reg;
      ev = '0;
      ev[plldh_pkg::IRQ_LOCK] = !lock_reg && lock_next;
      ev[plldh_pkg::IRQ_LOSS] = lock_reg && !lock_next;
      ev[plldh_pkg::IRQ_HO_IN] = !ho_reg && ho_next;
      ev[plldh_pkg::IRQ_HO_OUT] = ho_reg && !ho_next;
      ist_next = ist_reg;
      rdata_next = 32'h0000_0000;
      if (i_wr) begin
         case (i_addr)
            plldh_pkg::OFS_CTRL: begin
               cfg_next.mode = i_wdata[plldh_pkg::CTRL_MODE_LSB +: 2];
               cfg_next.track_en = i_wdata[plldh_pkg::CTRL_TRACK_BIT];
               cfg_next.manual_tune_select =
                  i_wdata[plldh_pkg::CTRL_MANSEL_BIT];
               cfg_next.lockloss_holdover_trigger_off =
                  i_wdata[plldh_pkg::CTRL_TRIGOFF_BIT];
               cfg_next.phase_window_size =
                  i_wdata[plldh_pkg::CTRL_WIN_LSB +: plldh_pkg::WIN_W];
            end
            plldh_pkg::OFS_COUNT: begin
               cfg_next.lock_qualify_count = i_wdata[plldh_pkg::CNT_W-1:0];
            end
            plldh_pkg::OFS_DAC: begin
               cfg_next.manual_tune_value = i_wdata[plldh_pkg::DAC_W-1:0];
            end
            plldh_pkg::OFS_IRQ_STAT: begin
               ist_next = ist_reg & ~i_wdata[plldh_pkg::IRQ_W-1:0];
            end
            plldh_pkg::OFS_IRQ_MASK: begin
               imask_next = i_wdata[plldh_pkg::IRQ_W-1:0];
            end
            default: begin
            end
         endcase
      end
      ist_next = ist_next | ev; // New events win over a clear.
      if (i_rd) begin
         case (i_addr)
            plldh_pkg::OFS_CTRL: begin
               rdata_next[plldh_pkg::CTRL_MODE_LSB +: 2] = cfg_reg.mode;
               rdata_next[plldh_pkg::CTRL_TRACK_BIT] = cfg_reg.track_en;
               rdata_next[plldh_pkg::CTRL_MANSEL_BIT] =
                  cfg_reg.manual_tune_select;
               rdata_next[plldh_pkg::CTRL_TRIGOFF_BIT] =
                  cfg_reg.lockloss_holdover_trigger_off;
               rdata_next[plldh_pkg::CTRL_WIN_LSB +: plldh_pkg::WIN_W] =
                  cfg_reg.phase_window_size;
            end
            plldh_pkg::OFS_COUNT: begin
               rdata_next[plldh_pkg::CNT_W-1:0] = cfg_reg.lock_qualify_count;
            end
            plldh_pkg::OFS_DAC: begin
               rdata_next[plldh_pkg::DAC_W-1:0] = cfg_reg.manual_tune_value;
            end
            plldh_pkg::OFS_STATUS: begin
               rdata_next[0] = lock_reg;
               rdata_next[1] = ho_reg;
               rdata_next[2] = ref_ok;
               rdata_next[16 +: plldh_pkg::CNT_W] = qcnt_reg;
            end
            plldh_pkg::OFS_IRQ_STAT: begin
               rdata_next[plldh_pkg::IRQ_W-1:0] = ist_reg;
            end
            plldh_pkg::OFS_IRQ_MASK: begin
               rdata_next[plldh_pkg::IRQ_W-1:0] = imask_reg;
            end
            default: begin
               rdata_next = 32'h0000_0000;
            end
         endcase
      end
      irq_next = |(ist_next & imask_next);
   end

   // All state registers; the clock enable freezes everything.
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cfg_reg <= '{mode: 2'h0, track_en: 1'b0, manual_tune_select: 1'b0,
            lockloss_holdover_trigger_off: 1'b0,
            phase_window_size: plldh_pkg::WIN_RST,
            lock_qualify_count: plldh_pkg::COUNT_RST,
            manual_tune_value: plldh_pkg::DAC_MID};
         ist_reg <= plldh_pkg::IRQ_RST;
         imask_reg <= plldh_pkg::IRQ_RST;
         rdata_reg <= 32'h0000_0000;
         irq_reg <= 1'b0;
         qcnt_reg <= '0;
         lock_reg <= 1'b0;
         ho_reg <= 1'b0;
         relock_reg <= 1'b0;
         held_reg <= plldh_pkg::DAC_MID;
         tune_reg <= plldh_pkg::DAC_MID;
      end else if (i_ce) begin
         cfg_reg <= cfg_next;
         ist_reg <= ist_next;
         imask_reg <= imask_next;
         rdata_reg <= rdata_next;
         irq_reg <= irq_next;
         qcnt_reg <= qcnt_next;
         lock_reg <= lock_next;
         ho_reg <= ho_next;
         relock_reg <= relock_next;
         held_reg <= held_next;
         tune_reg <= tune_next;
      end
   end

   assign o_rdata = rdata_reg;
   assign o_lock_indication = lock_reg;
   assign o_holdover = ho_reg;
   assign o_relock_start = relock_reg;
   assign o_tune_code = tune_reg;
   assign o_tune_hold = ho_reg;
   assign o_irq = irq_reg;

   // Checks, gathered after the registers, each tagged with the rule that it guards.

   // Any comparison outside the window drops lock at the next edge.
   lock_drop_a: assert property ( // R2
      @(posedge i_core_clk) disable iff (!i_arst_n)
      i_ce && i_cmp_strobe && !in_win |=> !o_lock_indication)
      else $error("lock held after out-of-window comparison");

   // Lock only rises on the edge that takes an in-window comparison.
   lock_rise_a: assert property ( // R1
      @(posedge i_core_clk) disable iff (!i_arst_n)
      $rose(o_lock_indication) |-> $past(in_win) && $past(i_cmp_strobe))
      else $error("lock rose without in-window comparison");

   // Lock never rises before the programmed count has been met.
   count_reach_a: assert property ( // R10
      @(posedge i_core_clk) disable iff (!i_arst_n)
      $rose(o_lock_indication) |->
      $past(qcnt_reg) + 14'h0001 >= $past(cfg_reg.lock_qualify_count))
      else $error("lock rose before the qualify count was met");

   // Holdover is only ever entered on the edge at which lock falls.
   ho_entry_a: assert property ( // R3
      @(posedge i_core_clk) disable iff (!i_arst_n)
      $rose(o_holdover) |-> $fell(o_lock_indication))
      else $error("holdover entered without lock loss");

   // A lost lock with holdover enabled and the trigger armed must enter holdover.
   ho_enter_a: assert property ( // R3
      @(posedge i_core_clk) disable iff (!i_arst_n)
      i_ce && ho_enabled && !o_holdover && o_lock_indication &&
      !cfg_reg.lockloss_holdover_trigger_off && i_cmp_strobe && !in_win
      |=> o_holdover)
      else $error("lock lost but holdover not entered");

   // With the trigger turned off a lost lock leaves holdover alone.
   trig_off_a: assert property ( // R3
      @(posedge i_core_clk) disable iff (!i_arst_n)
      i_ce && !o_holdover && cfg_reg.lockloss_holdover_trigger_off
      |=> !o_holdover)
      else $error("holdover entered with trigger turned off");

   // Any mode other than holdover-on keeps the block out of holdover.
   // The enable term matters: a frozen cycle keeps the old state.
   ho_mode_a: assert property ( // R5
      @(posedge i_core_clk) disable iff (!i_arst_n)
      $past(i_ce) && $past(cfg_reg.mode) != plldh_pkg::HOLDOVER_MODE_ON
      |-> !o_holdover)
      else $error("holdover while mode disabled");

   // A valid reference ends holdover, clears the count, restarts locking.
   ho_leave_a: assert property ( // R4
      @(posedge i_core_clk) disable iff (!i_arst_n)
      i_ce && o_holdover && ref_ok |=> !o_holdover && o_relock_start &&
      !o_lock_indication && qcnt_reg == 14'h0000)
      else $error("holdover not left with a valid reference");

   // Every exit taken in holdover mode comes with a relock pulse.
   ho_exit_a: assert property ( // R4
      @(posedge i_core_clk) disable iff (!i_arst_n)
      $fell(o_holdover) && $past(ho_enabled) |-> o_relock_start)
      else $error("holdover exit without relock");

   // The relock pulse lasts one enabled cycle only.
   relock_pulse_a: assert property ( // R4
      @(posedge i_core_clk) disable iff (!i_arst_n)
      i_ce && o_relock_start |=> !o_relock_start)
      else $error("relock pulse longer than one cycle");

   // Manual select drives the programmed manual value in holdover.
   manual_tune_a: assert property ( // R7
      @(posedge i_core_clk) disable iff (!i_arst_n)
      i_ce && o_holdover && cfg_reg.manual_tune_select |=>
      o_tune_code == $past(cfg_reg.manual_tune_value))
      else $error("manual tune value not driven");

   // With neither manual nor tracking, holdover parks at mid range.
   tune_mid_a: assert property ( // R8
      @(posedge i_core_clk) disable iff (!i_arst_n)
      i_ce && o_holdover && !cfg_reg.manual_tune_select &&
      !cfg_reg.track_en |=> o_tune_code == plldh_pkg::DAC_MID)
      else $error("holdover tune not at mid range");

   // Tracking holdover drives the value captured while locked.
   tune_track_a: assert property ( // R6
      @(posedge i_core_clk) disable iff (!i_arst_n)
      i_ce && o_holdover && !cfg_reg.manual_tune_select &&
      cfg_reg.track_en |=> o_tune_code == $past(held_reg))
      else $error("holdover tune not the tracked value");

   // The held value stays put while tracking is turned off.
   track_off_a: assert property ( // R6
      @(posedge i_core_clk) disable iff (!i_arst_n)
      i_ce && !cfg_reg.track_en |=> held_reg == $past(held_reg))
      else $error("tracking while disabled");
endmodule // plldh_top

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the lock detect and holdover block.
// Assumes: Register port with one-cycle strobes, read data one cycle later.
// Notes: The qualify count is set to 3 so each lock needs few comparisons.
`timescale 1ns/1ps
module tb_top;
   typedef struct {
      logic [31:0] ctrl;
      logic [31:0] dac;
      logic hold;
      logic [31:0] code;
   } plldh_tb_case_t;
   logic i_core_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic i_ce = 1'b1;
   logic [plldh_pkg::ADDR_W-1:0] i_addr = '0;
   logic [31:0] i_wdata = 32'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_cmp_strobe = 1'b0;
   logic [plldh_pkg::WIN_W-1:0] i_phase_err = '0;
   logic [plldh_pkg::DAC_W-1:0] i_track_code = 10'h0AB;
   logic i_ref_valid = 1'b0;
   logic [31:0] o_rdata;
   logic o_lock_indication;
   logic o_holdover;
   logic o_relock_start;
   logic [plldh_pkg::DAC_W-1:0] o_tune_code;
   logic o_tune_hold;
   logic o_irq;
   int err_count = 0;
   int compares = 0;
   logic [31:0] rd_val;
   logic seen_pulse;
   plldh_tb_case_t cases [6];

   // Free-running core clock of 40 ns.
   always #20 i_core_clk = ~i_core_clk;

   plldh_top u_plldh_top (
      .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_ce(i_ce),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .i_cmp_strobe(i_cmp_strobe), .i_phase_err(i_phase_err),
      .i_track_code(i_track_code), .i_ref_valid(i_ref_valid),
      .o_rdata(o_rdata), .o_lock_indication(o_lock_indication),
      .o_holdover(o_holdover), .o_relock_start(o_relock_start),
      .o_tune_code(o_tune_code), .o_tune_hold(o_tune_hold), .o_irq(o_irq)
   );

   // Compares one value; case inequality so an unknown never matches.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One-cycle write strobe with address and data.
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
   endtask

   // One-cycle read strobe; data are sampled mid-way through the next cycle.
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge i_core_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      @(negedge i_core_clk);
      d = o_rdata;
   endtask

   // One phase comparison result of the given magnitude.
   task automatic stb(input logic [3:0] e);
      @(posedge i_core_clk);
      i_cmp_strobe <= 1'b1;
      i_phase_err <= e;
      @(posedge i_core_clk);
      i_cmp_strobe <= 1'b0;
   endtask

   // Lets registered outputs land before they are sampled.
   task automatic settle;
      repeat (2) @(posedge i_core_clk);
      @(negedge i_core_clk);
   endtask

   task automatic end_of_test;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Watchdog sized well above the few hundred cycles the tests need.
   initial begin
      #(40 * 20000);
      err_count++;
      end_of_test();
   end

   initial begin
      // Holdover configurations: mode, manual select, trigger-off, tracking.
      cases[0] = '{32'h0000040A, 32'h00000155, 1'b1, 32'h00000155};
      cases[1] = '{32'h0000040A, 32'h00000200, 1'b1, 32'h00000200};
      cases[2] = '{32'h00000402, 32'h00000155, 1'b1, 32'h00000200};
      cases[3] = '{32'h00000408, 32'h00000155, 1'b0, 32'h000000AB};
      cases[4] = '{32'h0000041A, 32'h00000155, 1'b0, 32'h000000AB};
      cases[5] = '{32'h00000406, 32'h00000155, 1'b1, 32'h000000AB};
      repeat (2) @(posedge i_core_clk);
      i_arst_n <= 1'b1;
      @(negedge i_core_clk);
      chk(32'(o_tune_code), 32'h00000200);
      chk({o_lock_indication, o_holdover, o_irq}, 32'h0);
      rd(plldh_pkg::OFS_CTRL, rd_val);
      chk(rd_val, 32'h00000400);
      rd(plldh_pkg::OFS_COUNT, rd_val);
      chk(rd_val, 32'h00002710);
      rd(plldh_pkg::OFS_DAC, rd_val);
      chk(rd_val, 32'h00000200);
      rd(4'hF, rd_val);
      chk(rd_val, 32'h0);
      $display("test reset done");

      // Consecutive in-window count of 3; a miss in between starts over.
      wr(plldh_pkg::OFS_COUNT, 32'h00000003);
      stb(4'h4);
      stb(4'h4);
      stb(4'h5);
      stb(4'h4);
      stb(4'h4);
      settle();
      chk(32'(o_lock_indication), 32'h0);
      stb(4'h4);
      settle();
      chk(32'(o_lock_indication), 32'h1);
      // A comparison taken while the enable is low must change nothing.
      @(posedge i_core_clk);
      i_ce <= 1'b0;
      stb(4'h5);
      settle();
      chk(32'(o_lock_indication), 32'h1);
      @(posedge i_core_clk);
      i_ce <= 1'b1;
      rd(plldh_pkg::OFS_IRQ_STAT, rd_val);
      chk(rd_val, 32'h00000001);
      chk(32'(o_irq), 32'h0);
      wr(plldh_pkg::OFS_IRQ_MASK, 32'h00000001);
      settle();
      chk(32'(o_irq), 32'h1);
      wr(plldh_pkg::OFS_IRQ_STAT, 32'h0000000F);
      settle();
      chk(32'(o_irq), 32'h0);
      stb(4'h5);
      settle();
      chk(32'(o_lock_indication), 32'h0);
      chk(32'(o_holdover), 32'h0);
      rd(plldh_pkg::OFS_IRQ_STAT, rd_val);
      chk(rd_val, 32'h00000002);
      $display("test lock done");

      // Each configuration: lock, lose lock, check holdover and tune code.
      foreach (cases[i]) begin
         @(posedge i_core_clk);
         i_ref_valid <= 1'b0;
         wr(plldh_pkg::OFS_CTRL, cases[i].ctrl);
         wr(plldh_pkg::OFS_DAC, cases[i].dac);
         repeat (6) @(posedge i_core_clk);
         repeat (3) stb(4'h4);
         settle();
         chk(32'(o_lock_indication), 32'h1);
         stb(4'h5);
         settle();
         chk(32'(o_holdover), 32'(cases[i].hold));
         chk(32'(o_tune_hold), 32'(cases[i].hold));
         chk(32'(o_tune_code), cases[i].code);
         if (cases[i].hold) begin
            rd(plldh_pkg::OFS_STATUS, rd_val);
            chk(rd_val & 32'h00000007, 32'h00000002);
            @(posedge i_core_clk);
            i_ref_valid <= 1'b1;
            seen_pulse = 1'b0;
            for (int k = 0; k < 12 && !seen_pulse; k++) begin
               @(negedge i_core_clk);
               seen_pulse = o_relock_start;
            end
            chk(32'(seen_pulse), 32'h1);
            @(negedge i_core_clk);
            chk(32'(o_relock_start), 32'h0);
            chk(32'(o_holdover), 32'h0);
         end
      end
      $display("test holdover done");
      end_of_test();
   end
endmodule // tb_top
